// ---- logic/wdsr_watchdog.sv ----
// Behaviour
// - time out after 2^(period+14) cycles
// - each period code step doubles time
// - period scaled by system prescale plus one
// - seven-bit prescaler feeds fourteen-bit counter
// - disabled after reset, stopped in power-down
// - expiry pulses internal cpu reset
// - 1e then e1 arms the watchdog
// - read-only running bit shows enabled
// - reads allowed mid-sequence, writes break it
// - wrong pair resets, sets both flags
// - 5a then a5 forces software reset
// - good software reset sets only its flag
// - overflow flag set; flags survive all but power-on reset
// - idle freeze bit stops count in idle
// - any reset clears the enable
// - control layout fixed, resets to zero
`timescale 1ns/1ps
`default_nettype none
`include "wdsr_regs.svh"

module wdsr_watchdog (
  // clock and power-on reset
  input wire logic clk_i,
  input wire logic rst_i,
  // other chip reset sources, one-cycle pulse
  input wire logic sys_reset_i,
  // special function register port
  input wire logic [7:0] sfr_addr_i,
  input wire logic sfr_wr_i,
  input wire logic [7:0] sfr_wdata_i,
  output logic [7:0] sfr_rdata_o,
  // power state and system timer prescale
  input wire logic idle_i,
  input wire logic powerdown_i,
  input wire logic [`WDSR_TPS_W-1:0] system_timer_prescale_i,
  // internal reset request to the cpu
  output logic wdt_reset_o
);

  wdsr_pkg::wdsr_ctrl_s c_q;
  wdsr_pkg::wdsr_ctrl_s c_d;
  logic expire;
  logic run;
  logic svc_wr;
  logic ctl_wr;
  logic feed_ok;
  logic soft_ok;
  logic bad_seq;
  logic any_reset;

  assign run = c_q.running && !powerdown_i && !(idle_i && c_q.idle_freeze);

  wdsr_timer u_timer (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .run_i(run),
    .clear_i(c_q.timer_clear),
    .period_i(c_q.period),
    .tps_i(system_timer_prescale_i),
    .expire_o(expire)
  );

  always_comb begin
    c_d = c_q;
    c_d.reset_pulse = 1'b0;
    c_d.timer_clear = 1'b0;
    svc_wr = sfr_wr_i && (sfr_addr_i == `WDSR_SERVICE_ADDR);
    ctl_wr = sfr_wr_i && (sfr_addr_i == `WDSR_CONTROL_ADDR);
    feed_ok = 1'b0;
    soft_ok = 1'b0;
    bad_seq = 1'b0;
    // other writes abort the half sequence
    if (sfr_wr_i && !svc_wr) begin
      c_d.seq = wdsr_pkg::SEQ_IDLE;
    end
    if (svc_wr) begin
      case (c_q.seq)
        wdsr_pkg::SEQ_IDLE: begin
          if (sfr_wdata_i == `WDSR_FEED_FIRST) begin
            c_d.seq = wdsr_pkg::SEQ_FEED_HALF;
          end else if (sfr_wdata_i == `WDSR_SOFT_FIRST) begin
            c_d.seq = wdsr_pkg::SEQ_SOFT_HALF;
          end else begin
            bad_seq = 1'b1;
          end
        end
        wdsr_pkg::SEQ_FEED_HALF: begin
          c_d.seq = wdsr_pkg::SEQ_IDLE;
          feed_ok = (sfr_wdata_i == `WDSR_FEED_SECOND);
          bad_seq = !feed_ok;
        end
        wdsr_pkg::SEQ_SOFT_HALF: begin
          c_d.seq = wdsr_pkg::SEQ_IDLE;
          soft_ok = (sfr_wdata_i == `WDSR_SOFT_SECOND);
          bad_seq = !soft_ok;
        end
        default: begin
          c_d.seq = wdsr_pkg::SEQ_IDLE;
        end
      endcase
    end
    if (ctl_wr) begin
      c_d.period = sfr_wdata_i[`WDSR_PERIOD_MSB:`WDSR_PERIOD_LSB];
      c_d.idle_freeze = sfr_wdata_i[`WDSR_IDLE_FREEZE_BIT];
      c_d.soft_reset_flag = sfr_wdata_i[`WDSR_SOFT_RESET_FLAG_BIT];
      c_d.overflow_flag = sfr_wdata_i[`WDSR_OVERFLOW_FLAG_BIT];
    end
    if (feed_ok) begin
      c_d.running = 1'b1;
      c_d.timer_clear = 1'b1;
    end
    // good soft pair or wrong pair sets software reset flag; set beats clear
    if (soft_ok || bad_seq) begin
      c_d.soft_reset_flag = 1'b1;
    end
    // wrong pair or expiry sets overflow
    if (bad_seq || (expire && c_q.running)) begin
      c_d.overflow_flag = 1'b1;
    end
    any_reset = soft_ok || bad_seq || (expire && c_q.running);
    c_d.reset_pulse = any_reset;
    if (any_reset || sys_reset_i) begin
      c_d.running = 1'b0;
      c_d.timer_clear = 1'b1;
      c_d.seq = wdsr_pkg::SEQ_IDLE;
    end
    // running bit read only, reserved bit zero
    case (sfr_addr_i)
      `WDSR_CONTROL_ADDR: begin
        c_d.rdata = {c_q.period, c_q.idle_freeze, 1'b0,
                     c_q.soft_reset_flag, c_q.overflow_flag, c_q.running};
      end
      default: begin
        c_d.rdata = 8'h00;
      end
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      c_q <= '0;
    end else begin
      c_q <= c_d;
    end
  end

  assign sfr_rdata_o = c_q.rdata;
  assign wdt_reset_o = c_q.reset_pulse;

endmodule

`default_nettype wire

// ---- logic/wdsr_regs.svh ----
`ifndef WDSR_REGS_SVH
`define WDSR_REGS_SVH

// special function register addresses
`define WDSR_CONTROL_ADDR 8'ha7
`define WDSR_SERVICE_ADDR 8'ha6

// watchdog_control field positions
`define WDSR_PERIOD_MSB 7
`define WDSR_PERIOD_LSB 5
`define WDSR_IDLE_FREEZE_BIT 4
`define WDSR_SOFT_RESET_FLAG_BIT 2
`define WDSR_OVERFLOW_FLAG_BIT 1
`define WDSR_RUNNING_BIT 0
`define WDSR_CONTROL_RESET 8'h00

// service register byte codes
`define WDSR_FEED_FIRST 8'h1e
`define WDSR_FEED_SECOND 8'he1
`define WDSR_SOFT_FIRST 8'h5a
`define WDSR_SOFT_SECOND 8'ha5

// timer geometry: 2^(period+14) cycles
`define WDSR_PERIOD_W 3
`define WDSR_PRESCALE_W 7
`define WDSR_COUNTER_W 14
`define WDSR_TPS_W 4
`define WDSR_COUNTER_LAST 14'h3fff

`endif

// ---- logic/wdsr_pkg.sv ----
package wdsr_pkg;

  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_FEED_HALF,
    SEQ_SOFT_HALF
  } wdsr_seq_e;

  typedef struct packed {
    logic [3:0] tps_cnt;
    logic [6:0] prescale;
    logic [13:0] counter;
    logic expire;
  } wdsr_timer_s;

  typedef struct packed {
    wdsr_seq_e seq;
    logic [2:0] period;
    logic idle_freeze;
    logic soft_reset_flag;
    logic overflow_flag;
    logic running;
    logic timer_clear;
    logic reset_pulse;
    logic [7:0] rdata;
  } wdsr_ctrl_s;

endpackage

// ---- logic/wdsr_timer.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "wdsr_regs.svh"

module wdsr_timer (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // control
  input wire logic run_i,
  input wire logic clear_i,
  input wire logic [`WDSR_PERIOD_W-1:0] period_i,
  input wire logic [`WDSR_TPS_W-1:0] tps_i,
  // time-out event
  output logic expire_o
);

  wdsr_pkg::wdsr_timer_s s_q;
  wdsr_pkg::wdsr_timer_s s_d;
  logic [`WDSR_PRESCALE_W-1:0] tap_last;
  logic tick;
  logic pre_wrap;

  always_comb begin
    s_d = s_q;
    s_d.expire = 1'b0;
    tap_last = `WDSR_PRESCALE_W'((8'h01 << period_i) - 8'h01);
    tick = run_i && (s_q.tps_cnt == tps_i);
    pre_wrap = tick && (s_q.prescale == tap_last);
    if (clear_i) begin
      s_d.tps_cnt = '0;
      s_d.prescale = '0;
      s_d.counter = '0;
    end else if (run_i) begin
      s_d.tps_cnt = tick ? '0 : s_q.tps_cnt + 4'h1;
      if (tick) begin
        s_d.prescale = pre_wrap ? '0 : s_q.prescale + 7'h01;
      end
      if (pre_wrap) begin
        s_d.counter = s_q.counter + 14'h0001;
        s_d.expire = (s_q.counter == `WDSR_COUNTER_LAST);
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign expire_o = s_q.expire;

endmodule

`default_nettype wire

// ---- test/wdsr_watchdog_sva.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "wdsr_regs.svh"
module wdsr_watchdog_sva (
  // clock and resets
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic sys_reset_i,
  // register port
  input wire logic [7:0] sfr_addr_i,
  input wire logic sfr_wr_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic [7:0] sfr_rdata_o,
  // power and reset out
  input wire logic idle_i,
  input wire logic powerdown_i,
  input wire logic [`WDSR_TPS_W-1:0] system_timer_prescale_i,
  input wire logic wdt_reset_o
);
  localparam logic [7:0] C = `WDSR_CONTROL_ADDR;
  localparam logic [7:0] S = `WDSR_SERVICE_ADDR;
  logic sw;
  assign sw = sfr_wr_i && sfr_addr_i == S;
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  a_pulse_single: assert property (
    wdt_reset_o |=> !wdt_reset_o) else $error("reset pulse too long");
  a_bad_byte: assert property (
    sw && !(sfr_wdata_i inside {8'h1e, 8'he1, 8'h5a, 8'ha5})
    |=> wdt_reset_o) else $error("bad byte gave no reset");
  a_soft_pair: assert property (
    sw && sfr_wdata_i == 8'h5a ##1 sw && sfr_wdata_i == 8'ha5
    |=> wdt_reset_o) else $error("soft pair gave no reset");
  a_other_zero: assert property (
    sfr_addr_i != C |=> sfr_rdata_o == 8'h00) else $error("stray read data");
  a_bit3_zero: assert property (
    sfr_addr_i == C |=> !sfr_rdata_o[3]) else $error("bit 3 not zero");
  a_period_back: assert property (
    sfr_wr_i && sfr_addr_i == C ##1 sfr_addr_i == C && !sfr_wr_i
    |=> sfr_rdata_o[7:4] == $past(sfr_wdata_i[7:4], 2))
    else $error("period field lost");
  a_cause_flagged: assert property (
    wdt_reset_o && sfr_addr_i == C |=> sfr_rdata_o[2:1] != 2'b00)
    else $error("no cause flag");
  a_enable_dropped: assert property (
    wdt_reset_o && sfr_addr_i == C |=> !sfr_rdata_o[0])
    else $error("still running after reset");
  a_reset_quiet: assert property (
    $fell(rst_i) |-> !wdt_reset_o && sfr_rdata_o == 8'h00)
    else $error("not quiet after reset");
  a_pd_quiet: assert property (
    (powerdown_i && !sfr_wr_i)[*4] |-> !wdt_reset_o)
    else $error("reset in power-down");
  cover property (sw && sfr_wdata_i == 8'he1);
  cover property (wdt_reset_o && sfr_addr_i == C);
  cover property (powerdown_i[*4]);
endmodule
bind wdsr_watchdog wdsr_watchdog_sva u_sva (.clk_i, .rst_i, .sys_reset_i,
  .sfr_addr_i, .sfr_wr_i, .sfr_wdata_i, .sfr_rdata_o, .idle_i,
  .powerdown_i, .system_timer_prescale_i, .wdt_reset_o);
`default_nettype wire

// ---- test/wdsr_watchdog_test.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "wdsr_regs.svh"
module wdsr_watchdog_test;
  localparam logic [7:0] C = `WDSR_CONTROL_ADDR;
  localparam logic [7:0] S = `WDSR_SERVICE_ADDR;
  logic clk_i, rst_i, sys_reset_i, sfr_wr_i, idle_i, powerdown_i, wdt_reset_o;
  logic [7:0] sfr_addr_i, sfr_wdata_i, sfr_rdata_o;
  logic [`WDSR_TPS_W-1:0] system_timer_prescale_i;
  int miscompares, samples_checked, n;
  wdsr_watchdog DUT (.clk_i, .rst_i, .sys_reset_i, .sfr_addr_i, .sfr_wr_i,
    .sfr_wdata_i, .sfr_rdata_o, .idle_i, .powerdown_i,
    .system_timer_prescale_i, .wdt_reset_o);
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  task automatic wrap_up();
    if (miscompares == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic fail(input string m);
    $display("CHECK FAILED %0t %s", $time, m);
    miscompares++;
  endtask
  // strobe stays up for back-to-back writes; idle or rd lowers it
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr_i = a;
    sfr_wdata_i = d;
    sfr_wr_i = 1'b1;
    @(posedge clk_i);
    #1;
  endtask
  task automatic idle(input int k);
    sfr_wr_i = 1'b0;
    sfr_addr_i = C;
    repeat (k) begin
      @(posedge clk_i);
      #1;
    end
  endtask
  // bounded wait for the reset pulse, counted from the call
  task automatic expiry(input int lo, input int hi);
    n = 0;
    while (wdt_reset_o !== 1'b1 && n < 40000) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    samples_checked++;
    if (n < lo || n > hi) fail("time-out period");
    if (n >= 40000) wrap_up();
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    sfr_wr_i = 1'b0;
    sfr_addr_i = a;
    @(posedge clk_i);
    #1;
    samples_checked++;
    if (sfr_rdata_o !== e) fail("read data");
  endtask
  initial begin
    rst_i = 1'b1;
    {sys_reset_i, sfr_wr_i, idle_i, powerdown_i} = 4'h0;
    sfr_addr_i = 8'h00;
    sfr_wdata_i = 8'h00;
    system_timer_prescale_i = '0;
    miscompares = 0;
    samples_checked = 0;
    repeat (8) @(posedge clk_i);
    #1 rst_i = 1'b0;
    rd(C, 8'h00);
    wr(C, 8'hff);
    rd(C, 8'hf6);
    wr(C, 8'h00);
    rd(C, 8'h00);
    rd(S, 8'h00);
    rd(8'h55, 8'h00);
    wr(S, 8'h1e);
    rd(C, 8'h00);
    wr(S, 8'he1);
    idle(1);
    rd(C, 8'h01);
    powerdown_i = 1'b1;
    idle(5);
    powerdown_i = 1'b0;
    sys_reset_i = 1'b1;
    idle(1);
    sys_reset_i = 1'b0;
    rd(C, 8'h00);
    wr(S, 8'h5a);
    wr(S, 8'ha5);
    idle(2);
    rd(C, 8'h04);
    wr(C, 8'h00);
    wr(S, 8'h33);
    idle(2);
    rd(C, 8'h06);
    wr(C, 8'h00);
    wr(S, 8'h1e);
    wr(S, 8'he1);
    idle(0);
    expiry(16380, 16390);
    idle(1);
    rd(C, 8'h02);
    sys_reset_i = 1'b1;
    idle(1);
    sys_reset_i = 1'b0;
    rd(C, 8'h02);
    // feed part-way: full period must restart from the feed
    wr(S, 8'h1e);
    wr(S, 8'he1);
    idle(3000);
    wr(S, 8'h1e);
    wr(S, 8'he1);
    idle(0);
    expiry(16380, 16390);
    // frozen idle cycles must not count
    wr(C, 8'h10);
    wr(S, 8'h1e);
    wr(S, 8'he1);
    idle_i = 1'b1;
    idle(2000);
    idle_i = 1'b0;
    expiry(16380, 16390);
    // system prescale of one doubles the period
    system_timer_prescale_i = 4'h1;
    wr(S, 8'h1e);
    wr(S, 8'he1);
    idle(0);
    expiry(32765, 32775);
    wrap_up();
  end
endmodule
`default_nettype wire
